// ===== pid_mode_supervisor.sv
// What this block does
// - open loop until output reaches switchover frequency
// - stay closed loop after switchover despite low frequency
// - stop output after long low-frequency interval
// - resume when deviation reaches offset cancel level
// - suspended: sleep on, run off, loop on
// - codes 52,53,54 pick setpoint, measured, deviation
// - deviation display offset, zero shows 1000
// - analog outputs 100% scale, refuse deviation code
// - deviation input actions zero setpoint/measured monitors
// - speed or jog inputs override closed loop
// - operation mode 6 disables closed loop
// - actions 20,21 add auxiliary input to setpoint
// - closed loop only with both assignments zero
// - clamp loop command to calibration and general limits, other commands to general limits only
// - remote up/down ignored during closed loop
// - closed loop command starts from zero hertz
// - suspension only when detect time is not 9999
//
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/1ns
module pid_mode_supervisor
#(
	parameter int TICK_CYCLES = pid_pkg::TICK_CYCLES
)
(
	input  wire logic        CLK,
	input  wire logic        RESET,
	// register port
	input  wire logic [7:0]  ADDR,
	input  wire logic [31:0] WDATA,
	input  wire logic        WR,
	input  wire logic        RD,
	output logic      [31:0] RDATA,
	output logic             IRQ,
	// command terminals
	input  wire logic        RUN_CMD,
	input  wire logic        LOOP_SELECT_INPUT,
	input  wire logic        SPEED_SEL_HIGH,
	input  wire logic        SPEED_SEL_MID,
	input  wire logic        SPEED_SEL_LOW,
	input  wire logic        SPEED_SEL_EXT,
	input  wire logic        JOG_INPUT,
	input  wire logic        REMOTE_UP,
	input  wire logic        REMOTE_DOWN,
	// process values, 0.1 % steps
	input  wire logic [10:0] SETPOINT_IN,
	input  wire logic [11:0] AUX_IN,
	input  wire logic [10:0] MEAS_IN,
	input  wire logic [11:0] DEV_IN,
	// frequencies, 0.01 Hz steps
	input  wire logic [15:0] OUT_FREQ,
	input  wire logic [15:0] PID_FREQ,
	input  wire logic [15:0] NORMAL_FREQ,
	// towards the frequency path
	output logic      [15:0] FREQ_CMD,
	output logic             PID_BASE_CLEAR,
	output logic      [13:0] PID_SETPOINT,
	output logic      [13:0] PID_DEVIATION,
	output logic             REMOTE_UP_OK,
	output logic             REMOTE_DOWN_OK,
	// status terminals
	output logic             LOOP_ACTIVE,
	output logic             SUSPEND,
	output logic             RUNNING,
	// monitors
	output logic      [15:0] MAIN_DISPLAY,
	output logic      [15:0] PULSE_MONITOR_OUT,
	output logic      [15:0] ANALOG_MONITOR_OUT
);

	// limit a value into lo..hi, lo winning when they cross
	function automatic logic [15:0] clamp16
	(
		input logic [15:0] v,
		input logic [15:0] lo,
		input logic [15:0] hi
	);
		logic [15:0] t;
		t = (v > hi) ? hi : v;
		return (t < lo) ? lo : t;
	endfunction

	// choose a monitor quantity by selector code
	function automatic logic [15:0] mon_pick
	(
		input logic [7:0]  code,
		input logic [15:0] sp,
		input logic [15:0] mv,
		input logic [15:0] dv
	);
		if (code == pid_pkg::MON_SETPOINT)
			return sp;
		else if (code == pid_pkg::MON_MEAS)
			return mv;
		else if (code == pid_pkg::MON_DEV)
			return dv;
		else
			return 16'h0;
	endfunction

	// negative signed value becomes zero
	function automatic logic [15:0] floor0(input logic signed [13:0] v);
		return v[13] ? 16'h0 : {2'h0, v};
	endfunction

	// configuration registers
	logic [15:0] auto_sw_q;           // auto_switch_frequency
	logic [15:0] det_time_q;          // suspend_detect_time
	logic [15:0] det_level_q;         // suspend_detect_level
	logic [15:0] cancel_q;            // suspend_cancel_level
	logic [7:0]  action_q;            // loop_action_select
	logic [3:0]  opmode_q;            // operation_mode_select
	logic [7:0]  main_sel_q;          // main_display_select
	logic [7:0]  pulse_sel_q;         // pulse_monitor_select
	logic [7:0]  analog_sel_q;        // analog_monitor_select
	logic [7:0]  meas_assign_q;       // meas_input_assign
	logic [7:0]  aux_assign_q;        // aux_input_assign
	logic [15:0] bias_q;              // setpoint_bias_cal
	logic [15:0] gain_q;              // setpoint_gain_cal
	logic [15:0] max_q;               // general upper limit
	logic [15:0] min_q;               // general lower limit
	logic [pid_pkg::IRQ_W-1:0] irq_stat_q; // sticky events
	logic [pid_pkg::IRQ_W-1:0] irq_en_q;   // event enables

	// supervisor state
	pid_pkg::state_e state_q;
	pid_pkg::state_e state_d;
	logic        ovr_q;               // override seen last cycle

	// address decode
	wire sel_auto   = (ADDR == pid_pkg::OFS_AUTO_SW);
	wire sel_dtime  = (ADDR == pid_pkg::OFS_DET_TIME);
	wire sel_dlevel = (ADDR == pid_pkg::OFS_DET_LEVEL);
	wire sel_cancel = (ADDR == pid_pkg::OFS_CANCEL);
	wire sel_action = (ADDR == pid_pkg::OFS_ACTION);
	wire sel_opmode = (ADDR == pid_pkg::OFS_OPMODE);
	wire sel_mon    = (ADDR == pid_pkg::OFS_MON_SEL);
	wire sel_assign = (ADDR == pid_pkg::OFS_ASSIGN);
	wire sel_bias   = (ADDR == pid_pkg::OFS_BIAS_CAL);
	wire sel_gain   = (ADDR == pid_pkg::OFS_GAIN_CAL);
	wire sel_max    = (ADDR == pid_pkg::OFS_MAX_FREQ);
	wire sel_min    = (ADDR == pid_pkg::OFS_MIN_FREQ);
	wire sel_status = (ADDR == pid_pkg::OFS_STATUS);
	wire sel_istat  = (ADDR == pid_pkg::OFS_IRQ_STAT);
	wire sel_iclr   = (ADDR == pid_pkg::OFS_IRQ_CLR);
	wire sel_ien    = (ADDR == pid_pkg::OFS_IRQ_EN);

	// switchover beyond 400 Hz is refused, old value kept
	wire auto_ok = (WDATA[15:0] <= pid_pkg::AUTO_SW_MAX);

	// deviation code is not taken by the outputs
	wire pulse_ok  = (WDATA[15:8] != pid_pkg::MON_DEV);
	wire analog_ok = (WDATA[23:16] != pid_pkg::MON_DEV);

	// action decode
	wire act_dev = (action_q == pid_pkg::ACT_DEV_REV)
		| (action_q == pid_pkg::ACT_DEV_FWD);
	wire act_sum = (action_q == pid_pkg::ACT_SUM_REV)
		| (action_q == pid_pkg::ACT_SUM_FWD);

	// speed or jog request overrides the loop
	wire ovr = SPEED_SEL_HIGH | SPEED_SEL_MID | SPEED_SEL_LOW
		| SPEED_SEL_EXT | JOG_INPUT;

	// loop allowed: selected, no override, mode and assignments fit
	wire loop_req = LOOP_SELECT_INPUT
		& ~ovr
		& (opmode_q != pid_pkg::MODE_SWITCHOVER)
		& (meas_assign_q == 8'h0)
		& (aux_assign_q == 8'h0)
		& (act_dev | act_sum);

	// open-loop start only when a threshold is set and not reached
	wire need_open = (auto_sw_q != 16'h0) & (OUT_FREQ < auto_sw_q);

	// setpoint with optional auxiliary sum
	wire signed [13:0] aux_ext = {{2{AUX_IN[11]}}, AUX_IN};
	wire signed [13:0] sp_sum  = $signed({3'h0, SETPOINT_IN})
		+ (act_sum ? aux_ext : 14'sh0);
	wire signed [13:0] meas_ext = $signed({3'h0, MEAS_IN});

	// deviation, external or computed
	wire signed [13:0] dev = act_dev ? $signed({{2{DEV_IN[11]}}, DEV_IN})
		: (sp_sum - meas_ext);

	// cancel threshold in 1 % steps, stored with 1000 % offset
	wire signed [16:0] cancel_pct = $signed({1'b0, cancel_q})
		- $signed({1'b0, pid_pkg::CANCEL_OFFSET});
	// widen before the product so large levels do not wrap
	wire signed [20:0] cancel_thr = 21'(cancel_pct) * 21'sd10;
	wire signed [20:0] dev_ext    = 21'(dev);
	wire cancel_hit = (dev_ext >= cancel_thr);

	// suspension armed only with a real detect time
	wire sleep_arm = (det_time_q != pid_pkg::DETECT_DISABLE)
		& (state_q == pid_pkg::ST_LOOP);
	wire below     = (OUT_FREQ < det_level_q);
	wire expired;

	// low-frequency interval timer
	sleep_timer #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_timer (
		.CLK     (CLK),
		.RESET   (RESET),
		.ARM     (sleep_arm),
		.BELOW   (below),
		.LIMIT   (det_time_q),
		.EXPIRED (expired)
	);

	// next-state decision
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			pid_pkg::ST_IDLE:
				// start in open loop or directly closed loop
				if (RUN_CMD && loop_req)
					state_d = need_open ? pid_pkg::ST_OPEN : pid_pkg::ST_LOOP;
			pid_pkg::ST_OPEN:
				// hand over once the threshold is reached
				if (!RUN_CMD || !loop_req)
					state_d = pid_pkg::ST_IDLE;
				else if (!need_open)
					state_d = pid_pkg::ST_LOOP;
			pid_pkg::ST_LOOP:
				// falling back under the switchover frequency no longer matters here
				if (!RUN_CMD || !loop_req)
					state_d = pid_pkg::ST_IDLE;
				else if (expired)
					state_d = pid_pkg::ST_SLEEP;
			pid_pkg::ST_SLEEP:
				// automatic wake on deviation
				if (!RUN_CMD || !loop_req)
					state_d = pid_pkg::ST_IDLE;
				else if (cancel_hit)
					state_d = pid_pkg::ST_LOOP;
			default:
				state_d = pid_pkg::ST_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
		begin
			state_q <= pid_pkg::ST_IDLE;
			ovr_q   <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			ovr_q   <= ovr;
		end
	end

	wire in_loop  = (state_q == pid_pkg::ST_LOOP);
	wire in_sleep = (state_q == pid_pkg::ST_SLEEP);

	// entry into the loop from outside it
	wire enter_loop = (state_d == pid_pkg::ST_LOOP)
		& (state_q != pid_pkg::ST_LOOP) & (state_q != pid_pkg::ST_SLEEP);

	// command for each state, taken from the state being entered so
	// the command is already zero in the first suspended cycle
	wire [15:0] loop_freq = clamp16(clamp16(PID_FREQ, bias_q, gain_q),
		min_q, max_q);
	wire [15:0] norm_freq = clamp16(NORMAL_FREQ, min_q, max_q);
	wire [15:0] freq_d = (state_d == pid_pkg::ST_SLEEP) ? 16'h0
		: enter_loop ? 16'h0
		: (state_d == pid_pkg::ST_LOOP) ? loop_freq : norm_freq;

	// monitor quantities
	wire [15:0] sp_mon  = act_dev ? 16'h0 : floor0(sp_sum);
	wire [15:0] mv_mon  = act_dev ? 16'h0 : floor0(meas_ext);
	wire signed [13:0] dev_show = dev
		+ $signed(pid_pkg::DEV_ZERO_SHOW[13:0]);
	wire [15:0] dv_mon  = floor0(dev_show);
	wire [15:0] sp_fs   = (sp_mon > pid_pkg::FULL_SCALE)
		? pid_pkg::FULL_SCALE : sp_mon;
	wire [15:0] mv_fs   = (mv_mon > pid_pkg::FULL_SCALE)
		? pid_pkg::FULL_SCALE : mv_mon;

	// events for the interrupt status
	wire [pid_pkg::IRQ_W-1:0] ev;
	assign ev[pid_pkg::IRQ_LOOP_ON]  = enter_loop;
	assign ev[pid_pkg::IRQ_SUSPEND]  = in_loop & (state_d == pid_pkg::ST_SLEEP);
	assign ev[pid_pkg::IRQ_RESUME]   = in_sleep & (state_d == pid_pkg::ST_LOOP);
	assign ev[pid_pkg::IRQ_OVERRIDE] = ovr & ~ovr_q & LOOP_SELECT_INPUT;
	wire [pid_pkg::IRQ_W-1:0] clr = (WR && sel_iclr)
		? WDATA[pid_pkg::IRQ_W-1:0] : '0;

	// outputs towards the frequency path and terminals
	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
		begin
			FREQ_CMD       <= 16'h0;
			PID_BASE_CLEAR <= 1'b0;
			PID_SETPOINT   <= 14'h0;
			PID_DEVIATION  <= 14'h0;
			LOOP_ACTIVE    <= 1'b0;
			SUSPEND        <= 1'b0;
			RUNNING        <= 1'b0;
		end
		else
		begin
			FREQ_CMD       <= freq_d;
			PID_BASE_CLEAR <= enter_loop;
			PID_SETPOINT   <= sp_sum;
			PID_DEVIATION  <= dev;
			LOOP_ACTIVE    <= (state_d == pid_pkg::ST_LOOP)
				| (state_d == pid_pkg::ST_SLEEP);
			SUSPEND        <= (state_d == pid_pkg::ST_SLEEP);
			RUNNING        <= RUN_CMD & (state_d != pid_pkg::ST_SLEEP);
		end
	end

	// monitor outputs
	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
		begin
			MAIN_DISPLAY       <= 16'h0;
			PULSE_MONITOR_OUT  <= 16'h0;
			ANALOG_MONITOR_OUT <= 16'h0;
		end
		else
		begin
			MAIN_DISPLAY       <= mon_pick(main_sel_q, sp_mon, mv_mon, dv_mon);
			PULSE_MONITOR_OUT  <= mon_pick(pulse_sel_q, sp_fs, mv_fs, 16'h0);
			ANALOG_MONITOR_OUT <= mon_pick(analog_sel_q, sp_fs, mv_fs, 16'h0);
		end
	end

	// remote frequency steps blocked while the loop runs
	assign REMOTE_UP_OK   = REMOTE_UP & ~LOOP_ACTIVE;
	assign REMOTE_DOWN_OK = REMOTE_DOWN & ~LOOP_ACTIVE;

	// level interrupt from enabled sticky bits
	assign IRQ = |(irq_stat_q & irq_en_q);

	// register writes
	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
		begin
			auto_sw_q     <= pid_pkg::RST_AUTO_SW;
			det_time_q    <= pid_pkg::RST_DET_TIME;
			det_level_q   <= pid_pkg::RST_DET_LEVEL;
			cancel_q      <= pid_pkg::RST_CANCEL;
			action_q      <= pid_pkg::RST_ACTION;
			opmode_q      <= pid_pkg::RST_OPMODE;
			main_sel_q    <= 8'h0;
			pulse_sel_q   <= 8'h0;
			analog_sel_q  <= 8'h0;
			meas_assign_q <= 8'h0;
			aux_assign_q  <= 8'h0;
			bias_q        <= pid_pkg::RST_ZERO16;
			gain_q        <= pid_pkg::RST_GAIN_CAL;
			max_q         <= pid_pkg::RST_MAX_FREQ;
			min_q         <= pid_pkg::RST_ZERO16;
			irq_en_q      <= '0;
		end
		else if (WR)
		begin
			if (sel_auto && auto_ok)
				auto_sw_q <= WDATA[15:0];
			if (sel_dtime)
				det_time_q <= WDATA[15:0];
			if (sel_dlevel)
				det_level_q <= WDATA[15:0];
			if (sel_cancel)
				cancel_q <= WDATA[15:0];
			if (sel_action)
				action_q <= WDATA[7:0];
			if (sel_opmode)
				opmode_q <= WDATA[3:0];
			if (sel_mon)
			begin
				main_sel_q <= WDATA[7:0];
				if (pulse_ok)
					pulse_sel_q <= WDATA[15:8];
				if (analog_ok)
					analog_sel_q <= WDATA[23:16];
			end
			if (sel_assign)
			begin
				meas_assign_q <= WDATA[7:0];
				aux_assign_q  <= WDATA[15:8];
			end
			if (sel_bias)
				bias_q <= WDATA[15:0];
			if (sel_gain)
				gain_q <= WDATA[15:0];
			if (sel_max)
				max_q <= WDATA[15:0];
			if (sel_min)
				min_q <= WDATA[15:0];
			if (sel_ien)
				irq_en_q <= WDATA[pid_pkg::IRQ_W-1:0];
		end
	end

	// sticky events, a new event beats a clear
	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
			irq_stat_q <= '0;
		else
			irq_stat_q <= (irq_stat_q & ~clr) | ev;
	end

	// read mux, unmapped reads give zero
	logic [31:0] rd_d;
	always_comb
	begin
		rd_d = 32'h0;
		if (sel_auto)
			rd_d = {16'h0, auto_sw_q};
		else if (sel_dtime)
			rd_d = {16'h0, det_time_q};
		else if (sel_dlevel)
			rd_d = {16'h0, det_level_q};
		else if (sel_cancel)
			rd_d = {16'h0, cancel_q};
		else if (sel_action)
			rd_d = {24'h0, action_q};
		else if (sel_opmode)
			rd_d = {28'h0, opmode_q};
		else if (sel_mon)
			rd_d = {8'h0, analog_sel_q, pulse_sel_q, main_sel_q};
		else if (sel_assign)
			rd_d = {16'h0, aux_assign_q, meas_assign_q};
		else if (sel_bias)
			rd_d = {16'h0, bias_q};
		else if (sel_gain)
			rd_d = {16'h0, gain_q};
		else if (sel_max)
			rd_d = {16'h0, max_q};
		else if (sel_min)
			rd_d = {16'h0, min_q};
		else if (sel_status)
			rd_d = {28'h0, RUNNING, SUSPEND, LOOP_ACTIVE, state_q == pid_pkg::ST_OPEN};
		else if (sel_istat)
			rd_d = {28'h0, irq_stat_q};
		else if (sel_ien)
			rd_d = {28'h0, irq_en_q};
	end

	// read data stands one cycle after the strobe only
	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
			RDATA <= 32'h0;
		else
			RDATA <= RD ? rd_d : 32'h0;
	end

endmodule

// ===== pid_pkg.sv
package pid_pkg;

	// clock and suspension timer base
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_TIME_NS  = 100_000_000; // one detect-time unit, 0.1 s
	localparam int TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;

	// frequencies are in 0.01 Hz steps
	localparam logic [15:0] AUTO_SW_MAX    = 16'h9c40; // 400 Hz
	localparam logic [15:0] DETECT_DISABLE = 16'h270f; // 9999
	localparam logic [15:0] CANCEL_OFFSET  = 16'h03e8; // 1000 percent
	localparam logic [15:0] DEV_ZERO_SHOW  = 16'h03e8; // 0 % shown as 1000
	localparam logic [15:0] FULL_SCALE     = 16'h03e8; // 100.0 % in 0.1 %

	// monitor selector codes
	localparam logic [7:0] MON_SETPOINT = 8'h34; // 52
	localparam logic [7:0] MON_MEAS     = 8'h35; // 53
	localparam logic [7:0] MON_DEV      = 8'h36; // 54

	// loop action codes
	localparam logic [7:0] ACT_DEV_REV = 8'h0a; // 10
	localparam logic [7:0] ACT_DEV_FWD = 8'h0b; // 11
	localparam logic [7:0] ACT_SUM_REV = 8'h14; // 20
	localparam logic [7:0] ACT_SUM_FWD = 8'h15; // 21
	localparam logic [3:0] MODE_SWITCHOVER = 4'h6;

	// register offsets, byte addresses
	localparam logic [7:0] OFS_AUTO_SW   = 8'h00;
	localparam logic [7:0] OFS_DET_TIME  = 8'h04;
	localparam logic [7:0] OFS_DET_LEVEL = 8'h08;
	localparam logic [7:0] OFS_CANCEL    = 8'h0c;
	localparam logic [7:0] OFS_ACTION    = 8'h10;
	localparam logic [7:0] OFS_OPMODE    = 8'h14;
	localparam logic [7:0] OFS_MON_SEL   = 8'h18;
	localparam logic [7:0] OFS_ASSIGN    = 8'h1c;
	localparam logic [7:0] OFS_BIAS_CAL  = 8'h20;
	localparam logic [7:0] OFS_GAIN_CAL  = 8'h24;
	localparam logic [7:0] OFS_MAX_FREQ  = 8'h28;
	localparam logic [7:0] OFS_MIN_FREQ  = 8'h2c;
	localparam logic [7:0] OFS_STATUS    = 8'h30;
	localparam logic [7:0] OFS_IRQ_STAT  = 8'h34;
	localparam logic [7:0] OFS_IRQ_CLR   = 8'h38;
	localparam logic [7:0] OFS_IRQ_EN    = 8'h3c;

	// values after reset
	localparam logic [15:0] RST_AUTO_SW   = 16'h0000; // 0 = no switchover
	localparam logic [15:0] RST_DET_TIME  = 16'h270f;
	localparam logic [15:0] RST_DET_LEVEL = 16'h0000;
	localparam logic [15:0] RST_CANCEL    = 16'h03e8;
	localparam logic [7:0]  RST_ACTION    = 8'h0a;
	localparam logic [3:0]  RST_OPMODE    = 4'h0;
	localparam logic [15:0] RST_GAIN_CAL  = 16'h1770; // 60 Hz
	localparam logic [15:0] RST_MAX_FREQ  = 16'h2ee0; // 120 Hz
	localparam logic [15:0] RST_ZERO16    = 16'h0000;

	// interrupt bit positions
	localparam int IRQ_LOOP_ON   = 0;
	localparam int IRQ_SUSPEND   = 1;
	localparam int IRQ_RESUME    = 2;
	localparam int IRQ_OVERRIDE  = 3;
	localparam int IRQ_W         = 4;

	// supervisor states
	typedef enum logic [1:0]
	{
		ST_IDLE  = 2'b00,
		ST_OPEN  = 2'b01,
		ST_LOOP  = 2'b10,
		ST_SLEEP = 2'b11
	} state_e;

endpackage

// ===== sleep_timer.sv
`timescale 1ns/1ns
// counts how long the output frequency stays under the detect level
module sleep_timer
#(
	parameter int TICK_CYCLES = pid_pkg::TICK_CYCLES
)
(
	input  wire logic        CLK,
	input  wire logic        RESET,
	input  wire logic        ARM,
	input  wire logic        BELOW,
	input  wire logic [15:0] LIMIT,
	output logic             EXPIRED
);

	logic [31:0] pre_q;   // cycles within one 0.1 s unit
	logic [15:0] units_q; // whole units spent below the level
	wire         run   = ARM & BELOW;
	wire         tick  = (pre_q == 32'(TICK_CYCLES - 1));

	// any climb back to the level restarts from zero
	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
		begin
			pre_q   <= 32'h0;
			units_q <= 16'h0;
		end
		else if (!run)
		begin
			pre_q   <= 32'h0;
			units_q <= 16'h0;
		end
		else if (tick)
		begin
			pre_q <= 32'h0;
			if (units_q != 16'hffff)
				units_q <= units_q + 16'h1;
		end
		else
			pre_q <= pre_q + 32'h1;
	end

	// longer than the set time, not equal to it
	assign EXPIRED = run & (units_q > LIMIT);

endmodule

// ===== pid_supervisor_properties.sv
`timescale 1ns/1ns
// port relations of the loop supervisor
module pid_supervisor_props
(
	input wire logic        CLK,
	input wire logic        RESET,
	input wire logic        RD,
	input wire logic        WR,
	input wire logic [31:0] RDATA,
	input wire logic        RUN_CMD,
	input wire logic        LOOP_SELECT_INPUT,
	input wire logic        SPEED_SEL_HIGH,
	input wire logic        SPEED_SEL_MID,
	input wire logic        SPEED_SEL_LOW,
	input wire logic        SPEED_SEL_EXT,
	input wire logic        JOG_INPUT,
	input wire logic        REMOTE_UP,
	input wire logic [15:0] FREQ_CMD,
	input wire logic        PID_BASE_CLEAR,
	input wire logic        REMOTE_UP_OK,
	input wire logic        LOOP_ACTIVE,
	input wire logic        SUSPEND,
	input wire logic        RUNNING,
	input wire logic [15:0] PULSE_MONITOR_OUT,
	input wire logic [15:0] ANALOG_MONITOR_OUT
);
	// any speed or jog request
	wire ovr = SPEED_SEL_HIGH | SPEED_SEL_MID | SPEED_SEL_LOW | SPEED_SEL_EXT | JOG_INPUT;
	// all checks on the one clock, quiet in reset
	default clocking @(posedge CLK); endclocking
	default disable iff (RESET);
	chk_sleep_flags: assert property (SUSPEND |-> LOOP_ACTIVE && !RUNNING)
		else $error("sleep status flags wrong");
	chk_remote_block: assert property (REMOTE_UP_OK == (REMOTE_UP && !LOOP_ACTIVE))
		else $error("remote step passed in loop");
	chk_override_stop: assert property (LOOP_SELECT_INPUT && ovr |=> !LOOP_ACTIVE)
		else $error("loop kept under override");
	chk_entry_base: assert property ($rose(LOOP_ACTIVE) |-> PID_BASE_CLEAR && FREQ_CMD == 16'h0)
		else $error("loop entry not from zero");
	chk_clear_pulse: assert property (PID_BASE_CLEAR |=> !PID_BASE_CLEAR)
		else $error("base clear too long");
	chk_sleep_zero: assert property (SUSPEND |-> FREQ_CMD == 16'h0)
		else $error("command during sleep");
	chk_sleep_origin: assert property ($rose(SUSPEND) |-> $past(LOOP_ACTIVE))
		else $error("sleep not from loop");
	chk_loop_hold: assert property (LOOP_ACTIVE && RUN_CMD && LOOP_SELECT_INPUT && !ovr
		&& !$past(WR) |=> LOOP_ACTIVE) else $error("loop dropped");
	chk_monitor_clip: assert property (PULSE_MONITOR_OUT <= 16'h3e8
		&& ANALOG_MONITOR_OUT <= 16'h3e8) else $error("monitor above full scale");
	chk_read_idle: assert property (!$past(RD) |-> RDATA == 32'h0)
		else $error("read data outside slot");
endmodule
bind pid_mode_supervisor pid_supervisor_props u_props (.*);

// ===== feedback_model.sv
`timescale 1ns/1ns
// process side: speed follows the command, detector echoes the set level
module feedback_model
(
	input  wire logic        CLK,
	input  wire logic        RESET,
	input  wire logic        SLOW,
	input  wire logic [15:0] FREQ_CMD,
	input  wire logic [10:0] MEAS_SET,
	output logic      [15:0] OUT_FREQ,
	output logic      [10:0] MEAS_IN
);
	// slow drive climbs 0x100 a cycle, falls at once
	always_ff @(posedge CLK or posedge RESET)
	begin
		if (RESET)
		begin
			OUT_FREQ <= 16'h0;
			MEAS_IN  <= 11'h0;
		end
		else
		begin
			MEAS_IN  <= MEAS_SET;
			OUT_FREQ <= (SLOW && OUT_FREQ < FREQ_CMD) ? OUT_FREQ + 16'h100 : FREQ_CMD;
		end
	end
endmodule

// ===== tb_pid_mode_supervisor.sv
`timescale 1ns/1ns
// walks the supervisor through its modes and monitors
module tb_pid_mode_supervisor;
	logic        CLK, RESET, WR, RD, RUN_CMD, LOOP_SELECT_INPUT, REMOTE_UP, REMOTE_DOWN;
	logic        SPEED_SEL_HIGH, SPEED_SEL_MID, SPEED_SEL_LOW, SPEED_SEL_EXT, JOG_INPUT;
	logic        IRQ, PID_BASE_CLEAR, REMOTE_UP_OK, REMOTE_DOWN_OK, LOOP_ACTIVE, SUSPEND;
	logic        RUNNING, SLOW;
	logic [4:0]  ovr;
	logic [7:0]  ADDR;
	logic [31:0] WDATA, RDATA;
	logic [10:0] SETPOINT_IN, MEAS_IN, MEAS_SET;
	logic [11:0] AUX_IN, DEV_IN;
	logic [13:0] PID_SETPOINT, PID_DEVIATION;
	logic [15:0] OUT_FREQ, PID_FREQ, NORMAL_FREQ, FREQ_CMD;
	logic [15:0] MAIN_DISPLAY, PULSE_MONITOR_OUT, ANALOG_MONITOR_OUT;
	int          mismatches, cmp_count, i;
	// speed and jog terminals as one vector
	assign {SPEED_SEL_HIGH, SPEED_SEL_MID, SPEED_SEL_LOW, SPEED_SEL_EXT, JOG_INPUT} = ovr;
	pid_mode_supervisor #(.TICK_CYCLES(4)) DUT (.*);
	feedback_model PARTNER (.*);
	initial
	begin
		CLK = 1'b0;
		forever #5 CLK = ~CLK;
	end
	// value compare, counted
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge CLK);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge CLK);
		WR <= 1'b0;
	endtask
	// read strobe, data looked at in the next cycle
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge CLK);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge CLK);
		RD <= 1'b0;
		@(negedge CLK);
		cmp(RDATA, exp);
	endtask
	// bounded wait for a level
	task automatic await(ref logic s, input logic v);
		for (int k = 0; k < 80 && s !== v; k++)
			@(negedge CLK);
		cmp(s, v);
		if (s !== v)
			end_of_test();
	endtask
	// a setting that must drop the loop, then its removal
	task automatic refuse(input logic [7:0] a, input logic [31:0] v);
		wr(a, v);
		repeat (2) @(negedge CLK);
		cmp(LOOP_ACTIVE, 1'b0);
		wr(a, 32'h0);
		await(LOOP_ACTIVE, 1'b1);
	endtask
	task automatic end_of_test();
		$display("compares %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial
	begin
		{RESET, WR, RD, RUN_CMD, LOOP_SELECT_INPUT, REMOTE_UP, REMOTE_DOWN, ovr} = 12'h800;
		{ADDR, WDATA, SETPOINT_IN, MEAS_SET, AUX_IN, DEV_IN} = 0;
		{PID_FREQ, NORMAL_FREQ, SLOW} = {16'h0, 16'h2000, 1'b1};
		{mismatches, cmp_count} = 0;
		repeat (8) @(posedge CLK);
		RESET <= 1'b0;
		rd(pid_pkg::OFS_DET_TIME, 32'h270f);
		rd(pid_pkg::OFS_CANCEL, 32'h3e8);
		rd(8'h40, 32'h0);
		wr(pid_pkg::OFS_IRQ_EN, 32'h1);
		wr(pid_pkg::OFS_AUTO_SW, 32'h1000);
		RUN_CMD <= 1'b1;
		LOOP_SELECT_INPUT <= 1'b1;
		rd(pid_pkg::OFS_STATUS, 32'h9);
		await(LOOP_ACTIVE, 1'b1);
		cmp(IRQ, 1'b1);
		wr(pid_pkg::OFS_IRQ_CLR, 32'h1);
		@(negedge CLK) cmp(IRQ, 1'b0);
		// low speed in loop, timer disabled
		wr(pid_pkg::OFS_DET_LEVEL, 32'h200);
		REMOTE_UP <= 1'b1;
		REMOTE_DOWN <= 1'b1;
		repeat (30) @(negedge CLK);
		cmp(LOOP_ACTIVE, 1'b1);
		cmp(SUSPEND, 1'b0);
		cmp({REMOTE_UP_OK, REMOTE_DOWN_OK}, 2'b00);
		// command limits
		wr(pid_pkg::OFS_BIAS_CAL, 32'h100);
		wr(pid_pkg::OFS_GAIN_CAL, 32'h1000);
		wr(pid_pkg::OFS_MAX_FREQ, 32'h800);
		PID_FREQ <= 16'h3000;
		repeat (3) @(negedge CLK);
		cmp(FREQ_CMD, 16'h800);
		wr(pid_pkg::OFS_MAX_FREQ, 32'h2ee0);
		repeat (3) @(negedge CLK);
		cmp(FREQ_CMD, 16'h1000);
		@(posedge CLK);
		PID_FREQ <= 16'h10;
		repeat (3) @(negedge CLK);
		cmp(FREQ_CMD, 16'h100);
		for (i = 0; i < 5; i++)
		begin
			@(posedge CLK);
			ovr <= 5'h1 << i;
			repeat (2) @(negedge CLK);
			cmp(LOOP_ACTIVE, 1'b0);
			cmp({REMOTE_UP_OK, REMOTE_DOWN_OK}, 2'b11);
			@(posedge CLK);
			ovr <= 5'h0;
			await(LOOP_ACTIVE, 1'b1);
		end
		refuse(pid_pkg::OFS_OPMODE, 32'h6);
		refuse(pid_pkg::OFS_ASSIGN, 32'h1);
		refuse(pid_pkg::OFS_ASSIGN, 32'h100);
		// sleep with a recovery in mid-count
		@(posedge CLK);
		DEV_IN <= 12'hf9c;
		wr(pid_pkg::OFS_DET_TIME, 32'h2);
		repeat (8) @(posedge CLK);
		PID_FREQ <= 16'h400;
		repeat (4) @(posedge CLK);
		PID_FREQ <= 16'h10;
		repeat (10) @(negedge CLK);
		cmp(SUSPEND, 1'b0);
		await(SUSPEND, 1'b1);
		cmp({RUNNING, LOOP_ACTIVE}, 2'b01);
		cmp(FREQ_CMD, 16'h0);
		wr(pid_pkg::OFS_CANCEL, 32'h3e9);
		DEV_IN <= 12'h5;
		repeat (4) @(negedge CLK);
		cmp(SUSPEND, 1'b1);
		@(posedge CLK);
		DEV_IN <= 12'ha;
		await(SUSPEND, 1'b0);
		cmp(RUNNING, 1'b1);
		wr(pid_pkg::OFS_DET_TIME, 32'h270f);
		rd(pid_pkg::OFS_IRQ_STAT, 32'hf);
		cmp(IRQ, 1'b1);
		wr(pid_pkg::OFS_IRQ_EN, 32'h0);
		@(negedge CLK) cmp(IRQ, 1'b0);
		wr(pid_pkg::OFS_IRQ_CLR, 32'hf);
		rd(pid_pkg::OFS_IRQ_STAT, 32'h0);
		// monitors: 600 set point, 300 measured
		wr(pid_pkg::OFS_ACTION, 32'h14);
		{SETPOINT_IN, AUX_IN, MEAS_SET} <= {11'h1f4, 12'h64, 11'h12c};
		wr(pid_pkg::OFS_MON_SEL, 32'h343534);
		repeat (3) @(negedge CLK);
		cmp(MAIN_DISPLAY, 16'h258);
		cmp(PULSE_MONITOR_OUT, 16'h12c);
		cmp(ANALOG_MONITOR_OUT, 16'h258);
		cmp({PID_SETPOINT, PID_DEVIATION}, {14'h258, 14'h12c});
		wr(pid_pkg::OFS_MON_SEL, 32'h343636);
		rd(pid_pkg::OFS_MON_SEL, 32'h343536);
		cmp(MAIN_DISPLAY, 16'h514);
		@(posedge CLK);
		{SETPOINT_IN, MEAS_SET} <= {11'h5dc, 11'h6a4};
		repeat (4) @(negedge CLK);
		cmp(MAIN_DISPLAY, 16'h384);
		cmp(PID_DEVIATION, 14'h3f9c);
		cmp(ANALOG_MONITOR_OUT, 16'h3e8);
		wr(pid_pkg::OFS_ACTION, 32'ha);
		wr(pid_pkg::OFS_MON_SEL, 32'h343534);
		repeat (3) @(negedge CLK);
		cmp({MAIN_DISPLAY, PULSE_MONITOR_OUT}, 32'h0);
		// switchover above 400 Hz refused, the top value taken
		wr(pid_pkg::OFS_AUTO_SW, 32'h9c41);
		rd(pid_pkg::OFS_AUTO_SW, 32'h1000);
		wr(pid_pkg::OFS_AUTO_SW, 32'h9c40);
		rd(pid_pkg::OFS_AUTO_SW, 32'h9c40);
		cmp(LOOP_ACTIVE, 1'b1);
		end_of_test();
	end
endmodule
